/* rtl/access_frame_relay.sv */
`timescale 1ns/1ns
`include "relay_cfg.svh"
// Summary of operation
// - Invalid subscriber frames are dropped with no notice to the sender.
// - A frame running past 533 octets without a closing flag is invalid.
// - Fewer than 5 octets between the flags makes a frame invalid.
// - A bit count that is not a multiple of eight makes a frame invalid.
// - A frame whose FCS check fails is invalid.
// - A one-octet layer-2 address field makes a frame invalid.
// - Continuous flags are sent to the subscriber when nothing is pending.
// - Flag delimiting, octet alignment and zero insertion and extraction are done here.
// - Valid frames go upward on a channel chosen by layer-2 address, tagged first.
// - Exchange frames go to the subscriber with the envelope address removed.
// - The destination port is found by matching the provisioned envelope address.
// - Toward the subscriber: opening flag, information unchanged, new FCS, closing flag.
// - Flags and FCS are stripped before a valid frame goes upward.
// - The port's provisioned envelope address travels with the stripped frame.
module access_frame_relay #(
    parameter int EA_W = 13,
    parameter int CH_W = 2,
    parameter int MAX_OCT = `MAX_FRAME_OCTETS
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic rx_line_clk,
    input wire logic rx_line_data,
    input wire logic tx_line_clk,
    output logic tx_line_data,
    input wire logic [EA_W-1:0] port_env_addr,
    input wire logic [CH_W-1:0] chan_sapi0,
    input wire logic [CH_W-1:0] chan_other,
    output logic up_valid,
    input wire logic up_ready,
    output logic [7:0] up_data,
    output logic up_first,
    output logic up_last,
    output logic [EA_W-1:0] up_env_addr,
    output logic [CH_W-1:0] up_chan,
    input wire logic dn_valid,
    output logic dn_ready,
    input wire logic [7:0] dn_data,
    input wire logic dn_last,
    input wire logic [EA_W-1:0] dn_env_addr
);
    localparam int IW = $clog2(MAX_OCT + 1);
    localparam logic [IW-1:0] MAX_I = IW'(MAX_OCT);
    localparam logic [IW-1:0] MIN_I = IW'(`MIN_FRAME_OCTETS);

    if (MAX_OCT < `MIN_FRAME_OCTETS || EA_W < 1 || CH_W < 1) begin : g_bad_param
        $error("access_frame_relay: parameter out of range");
    end

    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
        crc_step = (c[0] ^ b) ? ((c >> 1) ^ `CRC_POLY) : (c >> 1);
    endfunction

    function automatic logic [2:0] ones_next(input logic [2:0] n, input logic b);
        ones_next = !b ? 3'h0 : (n == `ONES_SAT) ? n : n + 3'h1;
    endfunction

    // Line pins cross into the clock domain here; bit 0 rx clock, 1 rx data, 2 tx clock.
    logic [2:0] pins_s;
    pin_sync #(.W(3)) u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .ce(ce),
        .pin({tx_line_clk, rx_line_data, rx_line_clk}),
        .sync(pins_s)
    );

    // Receive side.
    logic rx_clk_d_r, in_frame_r;
    logic [2:0] ones_r, pl_n_r, bit_r;
    logic [6:0] pl_r;
    logic [7:0] oct_r;
    logic [15:0] crc_r;
    logic [IW-1:0] octs_r, len_r, rd_r;
    relay_pkg::octet_t buf_r [MAX_OCT];
    logic dr_r;

    wire rx_tick = ce & pins_s[0] & ~rx_clk_d_r;
    wire rb = pins_s[1];
    wire is_flag = rx_tick & ~rb & (ones_r == `FLAG_RUN);
    wire is_stuff = rx_tick & ~rb & (ones_r == `STUFF_RUN);
    wire is_abort = rx_tick & rb & (ones_r == `FLAG_RUN);
    wire push = rx_tick & ~is_flag & ~is_stuff & ~is_abort;
    // Seven bits are held back so that the flag's own bits never reach the octet path.
    wire commit = push & in_frame_r & (pl_n_r == 3'h7);
    wire cbit = pl_r[0];
    wire [7:0] oct_nxt = {cbit, oct_r[7:1]};
    wire oct_done = commit & (bit_r == 3'h7);
    wire too_long = oct_done & (octs_r == MAX_I);
    wire [15:0] rx_crc_nxt = crc_step(crc_r, cbit);
    wire len_ok = (bit_r == 3'h0) & (octs_r >= MIN_I);
    wire fcs_ok = (crc_r == `CRC_RESIDUE);
    wire addr_ok = ~buf_r[0][`EA_BIT];
    wire frame_ok = is_flag & in_frame_r & len_ok & fcs_ok & addr_ok;
    wire up_take = up_valid & up_ready;
    wire drain_end = up_take & up_last;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_clk_d_r <= 1'b0;
            ones_r <= 3'h0;
        end else if (ce) begin
            rx_clk_d_r <= pins_s[0];
            if (rx_tick) begin
                ones_r <= ones_next(ones_r, rb);
            end
        end
    end

    // An invalid frame is simply forgotten: no state leaves this block for it.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            in_frame_r <= 1'b0;
            pl_r <= 7'h00;
            pl_n_r <= 3'h0;
        end else if (is_flag) begin
            in_frame_r <= ~dr_r & ~frame_ok;
            pl_n_r <= 3'h0;
        end else if (is_abort | too_long) begin
            in_frame_r <= 1'b0;
        end else if (push) begin
            pl_r <= {rb, pl_r[6:1]};
            pl_n_r <= (pl_n_r == 3'h7) ? pl_n_r : pl_n_r + 3'h1;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            bit_r <= 3'h0;
            oct_r <= 8'h00;
            crc_r <= `CRC_INIT;
            octs_r <= '0;
        end else if (is_flag) begin
            bit_r <= 3'h0;
            crc_r <= `CRC_INIT;
            octs_r <= '0;
        end else if (commit) begin
            bit_r <= bit_r + 3'h1;
            oct_r <= oct_nxt;
            crc_r <= rx_crc_nxt;
            if (oct_done && !too_long) begin
                octs_r <= octs_r + IW'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (oct_done && !too_long) begin
            buf_r[octs_r] <= oct_nxt;
        end
    end

    // Upward stream; the buffer stays frozen while it drains, so frames that
    // close during a drain are lost. This trades a second buffer for area.
    wire [IW-1:0] rd_nxt = rd_r + IW'(1);
    wire [5:0] sapi = buf_r[0][7:2];

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            dr_r <= 1'b0;
            len_r <= '0;
            rd_r <= '0;
            up_valid <= 1'b0;
            up_data <= 8'h00;
            up_first <= 1'b0;
            up_last <= 1'b0;
            up_env_addr <= '0;
            up_chan <= '0;
        end else if (ce) begin
            if (frame_ok && !dr_r) begin
                dr_r <= 1'b1;
                len_r <= octs_r - IW'(2);
                rd_r <= IW'(1);
                up_valid <= 1'b1;
                up_data <= buf_r[0];
                up_first <= 1'b1;
                up_last <= 1'b0;
                up_env_addr <= port_env_addr;
                up_chan <= (sapi == 6'h00) ? chan_sapi0 : chan_other;
            end else if (drain_end) begin
                dr_r <= 1'b0;
                up_valid <= 1'b0;
                up_last <= 1'b0;
            end else if (up_take) begin
                up_data <= buf_r[rd_r];
                up_first <= 1'b0;
                up_last <= (rd_nxt == len_r);
                rd_r <= rd_nxt;
            end
        end
    end

    // Exchange side: one octet is held until the framer asks for it.
    logic hold_v_r, hold_last_r, dn_first_r, dn_match_r;
    logic [7:0] hold_r;
    wire dn_take = dn_valid & dn_ready;
    wire dn_hit = dn_first_r ? (dn_env_addr == port_env_addr) : dn_match_r;
    wire hold_fill = dn_take & dn_hit;

    // Transmit side.
    relay_pkg::tx_state_t tx_st_r;
    logic tx_clk_d_r, cur_last_r;
    logic [2:0] tx_ones_r;
    logic [4:0] tx_cnt_r;
    logic [15:0] tx_sh_r, tx_crc_r;
    wire tx_tick = ce & pins_s[2] & ~tx_clk_d_r;
    // Five ones at the end of the FCS still need their zero before the closing flag.
    wire stuff_ok = (tx_st_r != relay_pkg::TX_FLAG) | (tx_cnt_r == `OCTET_BITS);
    wire tx_stuff = tx_tick & stuff_ok & (tx_ones_r == `STUFF_RUN);
    wire tx_send = tx_tick & ~tx_stuff;
    wire tx_end = tx_send & (tx_cnt_r == 5'h01);
    wire [15:0] tx_crc_nxt = crc_step(tx_crc_r, tx_sh_r[0]);
    wire in_data = (tx_st_r == relay_pkg::TX_DATA);
    wire hold_take = tx_end & hold_v_r & ((tx_st_r == relay_pkg::TX_FLAG) | (in_data & ~cur_last_r));
    wire hold_v_nxt = (hold_v_r & ~hold_take) | hold_fill;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            hold_v_r <= 1'b0;
            hold_r <= 8'h00;
            hold_last_r <= 1'b0;
            dn_first_r <= 1'b1;
            dn_match_r <= 1'b0;
            dn_ready <= 1'b0;
        end else if (ce) begin
            hold_v_r <= hold_v_nxt;
            dn_ready <= ~hold_v_nxt;
            if (hold_fill) begin
                hold_r <= dn_data;
                hold_last_r <= dn_last;
            end
            if (dn_take) begin
                dn_first_r <= dn_last;
                dn_match_r <= dn_hit;
            end
        end
    end

    // An empty hold at an octet boundary ends the frame early with its FCS.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_clk_d_r <= 1'b0;
            tx_st_r <= relay_pkg::TX_FLAG;
            tx_sh_r <= {8'h00, `FLAG_OCTET};
            tx_cnt_r <= `OCTET_BITS;
            tx_ones_r <= 3'h0;
            tx_crc_r <= `CRC_INIT;
            cur_last_r <= 1'b0;
            tx_line_data <= 1'b1;
        end else if (ce) begin
            tx_clk_d_r <= pins_s[2];
            if (tx_stuff) begin
                tx_line_data <= 1'b0;
                tx_ones_r <= 3'h0;
            end else if (tx_send) begin
                tx_line_data <= tx_sh_r[0];
                tx_ones_r <= ones_next(tx_ones_r, tx_sh_r[0]);
                tx_sh_r <= tx_sh_r >> 1;
                tx_cnt_r <= tx_cnt_r - 5'h01;
                if (in_data) begin
                    tx_crc_r <= tx_crc_nxt;
                end
                if (tx_end) begin
                    unique case (tx_st_r)
                        relay_pkg::TX_FLAG: begin
                            if (hold_v_r) begin
                                tx_st_r <= relay_pkg::TX_DATA;
                                tx_sh_r <= {8'h00, hold_r};
                                tx_crc_r <= `CRC_INIT;
                                cur_last_r <= hold_last_r;
                            end else begin
                                tx_sh_r <= {8'h00, `FLAG_OCTET};
                            end
                            tx_cnt_r <= `OCTET_BITS;
                        end
                        relay_pkg::TX_DATA: begin
                            if (cur_last_r || !hold_v_r) begin
                                tx_st_r <= relay_pkg::TX_FCS;
                                tx_sh_r <= ~tx_crc_nxt;
                                tx_cnt_r <= `FCS_BITS;
                            end else begin
                                tx_sh_r <= {8'h00, hold_r};
                                cur_last_r <= hold_last_r;
                                tx_cnt_r <= `OCTET_BITS;
                            end
                        end
                        relay_pkg::TX_FCS: begin
                            tx_st_r <= relay_pkg::TX_FLAG;
                            tx_sh_r <= {8'h00, `FLAG_OCTET};
                            tx_cnt_r <= `OCTET_BITS;
                        end
                    endcase
                end
            end
        end
    end
endmodule

/* rtl/pin_sync.sv */
`timescale 1ns/1ns
module pin_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic [W-1:0] pin,
    output logic [W-1:0] sync
);
    // The first stage is read only by the second stage.
    logic [W-1:0] meta_r;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_r <= '0;
            sync <= '0;
        end else if (ce) begin
            meta_r <= pin;
            sync <= meta_r;
        end
    end
endmodule

/* rtl/relay_cfg.svh */
`ifndef RELAY_CFG_SVH
`define RELAY_CFG_SVH
`define FLAG_OCTET 8'h7E
`define CRC_INIT 16'hFFFF
`define CRC_POLY 16'h8408
`define CRC_RESIDUE 16'hF0B8
`define MAX_FRAME_OCTETS 533
`define MIN_FRAME_OCTETS 5
`define STUFF_RUN 3'h5
`define FLAG_RUN 3'h6
`define ONES_SAT 3'h7
`define FCS_BITS 5'h10
`define OCTET_BITS 5'h08
`define EA_BIT 0
`endif

/* rtl/relay_pkg.sv */
package relay_pkg;
    typedef enum logic [1:0] {TX_FLAG, TX_DATA, TX_FCS} tx_state_t;
    typedef logic [7:0] octet_t;
endpackage

/* tb/access_frame_relay_tb_top.sv */
`timescale 1ns/1ns
module access_frame_relay_tb_top;
    localparam int MAXO = 20;
    logic clk = 1'b0;
    logic sys_rst = 1'b0;
    logic ce = 1'b1;
    logic lclk, txd, rxd, up_valid, up_ready, up_first, up_last, dn_valid, dn_ready, dn_last;
    logic [12:0] pea = 13'h005A;
    logic [12:0] up_ea, dn_ea, ea_x;
    logic [1:0] c0 = 2'h1;
    logic [1:0] c1 = 2'h2;
    logic [1:0] up_chan, ch_x;
    logic [7:0] up_data, dn_data;
    logic [7:0] upq[$];
    logic [7:0] fr[$];
    int n_errors = 0;
    int compares = 0;
    int nfirst = 0;
    int n0, k;
    always #4 clk = ~clk;
    access_frame_relay #(.MAX_OCT(MAXO)) dut_u (.clk(clk), .sys_rst(sys_rst), .ce(ce),
        .rx_line_clk(lclk), .rx_line_data(rxd), .tx_line_clk(lclk), .tx_line_data(txd),
        .port_env_addr(pea), .chan_sapi0(c0), .chan_other(c1), .up_valid(up_valid),
        .up_ready(up_ready), .up_data(up_data), .up_first(up_first), .up_last(up_last),
        .up_env_addr(up_ea), .up_chan(up_chan), .dn_valid(dn_valid), .dn_ready(dn_ready),
        .dn_data(dn_data), .dn_last(dn_last), .dn_env_addr(dn_ea));
    sub_line_model line_u (.clk(clk), .line_clk(lclk), .rx_data(rxd), .tx_data(txd));
    always @(negedge clk) up_ready <= ($urandom % 4) != 0;
    always @(posedge clk) begin
        if (up_valid && up_ready && ce) begin
            upq.push_back(up_data);
            if (up_first) begin
                nfirst++;
                ch_x = up_chan;
                ea_x = up_ea;
            end
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic hang();
        check(32'h0, 32'h1);
        final_report();
    endtask
    function automatic logic [15:0] fcs16(input logic [7:0] d[$]);
        logic [15:0] c;
        c = 16'hFFFF;
        foreach (d[i]) for (int b = 0; b < 8; b++) c = (c[0] ^ d[i][b]) ? (c >> 1) ^ 16'h8408 : c >> 1;
        return ~c;
    endfunction
    // Builds n octets between flags: address (one octet if e is set, else two), payload, then FCS.
    function automatic void mk(input int n, input logic z, input logic e);
        logic [15:0] f;
        fr.delete();
        for (int i = 0; i < n - 2; i++) fr.push_back(8'($urandom));
        fr[0][0] = e;
        fr[1][0] = 1'b1;
        if (z) fr[0][7:2] = 6'h00;
        f = fcs16(fr);
        fr.push_back(f[7:0]);
        fr.push_back(f[15:8]);
    endfunction
    task automatic rx_ok();
        for (k = 0; k < 2000 && upq.size() < fr.size() - 2; k++) @(posedge clk);
        if (k == 2000) hang();
        repeat (4) @(negedge clk);
        check(upq.size(), fr.size() - 2);
        foreach (upq[i]) check(upq[i], fr[i]);
        check(nfirst, n0 + 1);
        check(ch_x, (fr[0][7:2] == 6'h00) ? c0 : c1);
        check(ea_x, pea);
        $display("test rx %0d done", fr.size());
    endtask
    task automatic dn_send(input logic [12:0] a);
        for (int i = 0; i < fr.size(); i++) begin
            @(negedge clk);
            {dn_valid, dn_data, dn_last, dn_ea} = {1'b1, fr[i], i == fr.size() - 1, a};
            for (k = 0; k < 5000; k++) begin
                @(posedge clk);
                if (dn_ready) break;
            end
            if (k == 5000) hang();
        end
        @(negedge clk);
        {dn_valid, dn_data} = {1'b0, ~dn_data};
    endtask
    initial begin
        void'($urandom(59));
        {dn_valid, dn_last, dn_data, dn_ea} = {10'h000, pea};
        up_ready = 1'b0;
        // A real rising edge on reset clears the design before its first clock.
        #1 sys_rst = 1'b1;
        repeat (20) @(negedge clk);
        sys_rst = 1'b0;
        repeat (2) @(negedge clk);
        n0 = line_u.nflags;
        for (k = 0; k < 2000 && line_u.nflags < n0 + 3; k++) @(posedge clk);
        check(k < 2000, 1);
        check(line_u.nframes, 0);
        if (k == 2000) hang();
        $display("test idle done");
        for (int i = 0; i < 10; i++) begin
            n0 = nfirst;
            upq.delete();
            if (i > 4) begin
                mk(i == 5 ? 4 : i == 6 ? MAXO + 1 : 8, 1'b0, i == 9);
                if (i == 7) fr[3] ^= 8'h10;
                line_u.send_frame(fr, i == 8 ? 3 : 0);
            end
            mk(i == 0 ? 5 : i == 1 ? MAXO : 5 + $urandom % (MAXO - 4), i[0], 1'b0);
            line_u.send_frame(fr, 0);
            rx_ok();
        end
        for (int i = 0; i < 3; i++) begin
            n0 = line_u.nframes;
            mk(5 + $urandom % 12, i[0], 1'b0);
            dn_send(pea + 13'h0001);
            mk(4 + $urandom % 11, 1'b0, 1'b0);
            void'(fr.pop_back());
            void'(fr.pop_back());
            dn_send(pea);
            for (k = 0; k < 20000 && line_u.nframes == n0; k++) @(posedge clk);
            if (k == 20000) hang();
            check(line_u.nframes, n0 + 1);
            check(line_u.last_q.size(), fr.size() + 2);
            foreach (fr[j]) check(line_u.last_q[j], fr[j]);
            k = fr.size();
            check({line_u.last_q[k + 1], line_u.last_q[k]}, fcs16(fr));
            $display("test tx %0d done", i);
        end
        final_report();
    end
endmodule

/* tb/frame_relay_monitor.sv */
`timescale 1ns/1ns
module frame_relay_monitor #(
    parameter int EA_W = 13,
    parameter int CH_W = 2
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic tx_line_data,
    input wire logic [EA_W-1:0] port_env_addr,
    input wire logic [CH_W-1:0] chan_sapi0,
    input wire logic [CH_W-1:0] chan_other,
    input wire logic up_valid,
    input wire logic up_ready,
    input wire logic [7:0] up_data,
    input wire logic up_first,
    input wire logic up_last,
    input wire logic [EA_W-1:0] up_env_addr,
    input wire logic [CH_W-1:0] up_chan,
    input wire logic dn_valid,
    input wire logic dn_ready,
    input wire logic dn_last,
    input wire logic [EA_W-1:0] dn_env_addr
);
    logic first_r;
    logic match_r;
    logic take_w;
    logic hit_w;
    logic upt_w;
    assign take_w = dn_valid && dn_ready && ce;
    assign hit_w = first_r ? (dn_env_addr == port_env_addr) : match_r;
    assign upt_w = up_valid && up_ready && ce;
    // The address is only judged on a frame's first octet, so remember the verdict.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            first_r <= 1'b1;
            match_r <= 1'b0;
        end else if (take_w) begin
            first_r <= dn_last;
            match_r <= hit_w;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_reset_quiet: assert property (disable iff (1'b0)
        sys_rst |-> !up_valid && !dn_ready && tx_line_data) else $error("reset outputs");
    a_up_hold: assert property (up_valid && !upt_w |=> up_valid && $stable(up_data)
        && $stable(up_first) && $stable(up_last)) else $error("up hold");
    a_next_octet: assert property (upt_w && !up_last |=> up_valid && !up_first)
        else $error("next octet");
    a_frame_end: assert property (upt_w && up_last |=> !up_valid) else $error("frame end");
    a_tag_addr: assert property (up_valid |-> up_env_addr == port_env_addr)
        else $error("env tag");
    a_tag_stable: assert property (up_valid && !up_first |-> $stable(up_env_addr)
        && $stable(up_chan)) else $error("tag moved");
    a_chan_pick: assert property (up_valid && up_first |->
        up_chan == ((up_data[7:2] == 6'h00) ? chan_sapi0 : chan_other)) else $error("chan");
    a_addr_two: assert property (up_valid && up_first |-> !up_data[0]) else $error("ea");
    a_hold_busy: assert property (take_w && hit_w |=> !dn_ready) else $error("hold busy");
    a_skip_fast: assert property (take_w && !hit_w |=> dn_ready) else $error("skip");
    a_hold_drains: assert property ($fell(dn_ready) |-> ##[1:1000] dn_ready)
        else $error("hold stuck");
    c_up_frame: cover property (upt_w && up_last);
    c_dn_frame: cover property (take_w && hit_w && dn_last);
    c_dn_skip: cover property (take_w && !hit_w);
endmodule
bind access_frame_relay frame_relay_monitor #(.EA_W(EA_W), .CH_W(CH_W)) mon_u (
    .clk, .sys_rst, .ce, .tx_line_data, .port_env_addr, .chan_sapi0, .chan_other,
    .up_valid, .up_ready, .up_data, .up_first, .up_last, .up_env_addr, .up_chan,
    .dn_valid, .dn_ready, .dn_last, .dn_env_addr);

/* tb/sub_line_model.sv */
`timescale 1ns/1ns
module sub_line_model (
    input wire logic clk,
    output logic line_clk,
    output logic rx_data,
    input wire logic tx_data
);
    localparam logic [7:0] FLAG = 8'h7E;
    int ones = 0;
    int nb = 0;
    int nflags = 0;
    int nframes = 0;
    logic [7:0] sh = 8'h00;
    logic [7:0] cur[$];
    logic [7:0] last_q[$];
    initial begin
        line_clk = 1'b0;
        rx_data = 1'b1;
    end
    // Sixteen system clocks a bit keeps the line well under a quarter of clk.
    always begin
        repeat (8) @(negedge clk);
        line_clk = ~line_clk;
    end
    task automatic put(input logic b);
        @(negedge line_clk);
        rx_data = b;
    endtask
    task automatic send_frame(input logic [7:0] d[$], input int extra);
        int run;
        logic b;
        run = 0;
        for (int i = 0; i < 8; i++) put(FLAG[i]);
        for (int i = 0; i < d.size() * 8 + extra; i++) begin
            b = (i < d.size() * 8) ? d[i / 8][i % 8] : 1'b0;
            put(b);
            run = b ? run + 1 : 0;
            if (run == 5) begin
                put(1'b0);
                run = 0;
            end
        end
        for (int i = 0; i < 8; i++) put(FLAG[i]);
    endtask
    // A zero after five ones is stuffing; after six it ends a flag.
    always @(negedge line_clk) begin
        if (tx_data) ones = ones + 1;
        if (tx_data || ones < 5) begin
            sh = {tx_data, sh[7:1]};
            nb = nb + 1;
            if (nb % 8 == 0) cur.push_back(sh);
        end else if (ones > 5) begin
            if (ones == 6 && nb % 8 == 7 && cur.size() > 0) begin
                last_q = cur;
                nframes++;
            end
            if (ones == 6) nflags++;
            nb = 0;
            cur.delete();
        end
        if (!tx_data) ones = 0;
    end
endmodule
